// *** irl_pkg.sv ***
// Purpose: shared constants and types of the ir link power and buffering block
// Assumes: 25 MHz system clock, fixed 9600 baud infrared link
// Notes:   counts of cycles are derived from times printed in their own units
package irl_pkg;
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned IR_BAUD      = 9600;
  localparam int unsigned BIT_CYC      = (CLK_HZ + IR_BAUD - 1) / IR_BAUD;
  localparam int unsigned IDLE_S       = 10;
  localparam int unsigned IDLE_CYC     = IDLE_S * CLK_HZ;
  localparam int unsigned HOST_DEPTH   = 29;
  localparam int unsigned CTS_ON_LEVEL = 23;
  localparam int unsigned IR_BLOCK     = 64;
  localparam int unsigned MIN_FRAME    = 6;
  localparam int unsigned OVH_BYTES    = 8;
  localparam logic [7:0]  OVH_FILL     = 8'hFF;
  localparam logic [7:0]  ID_NONE      = 8'h00;
  localparam int unsigned ID_LEN       = 10;

  typedef enum logic [1:0] {PWR_LOW, PWR_INIT, PWR_RUN} irl_pwr_t;
  typedef enum logic [1:0] {LINK_DISC, LINK_DISCOVERY, LINK_CONN} irl_link_t;
  typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_DATA} irl_tx_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } irl_byte_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } irl_rx_t;
endpackage : irl_pkg

// *** irl_skid.sv ***
// Purpose: two-entry buffer between the packet sequencer and the ir encoder
// Assumes: single clock, synchronous active-low reset
// Notes:   in_ready_o depends only on state, so a stall never loses a word
`timescale 1ns/10ps
module irl_skid #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_i,       // system clock
  input  wire logic         reset_n_i,   // synchronous reset, active low
  input  wire logic         in_valid_i,  // word offered
  input  wire logic [W-1:0] in_data_i,   // offered word
  output logic              in_ready_o,  // space for a word
  output logic              out_valid_o, // word presented
  output logic [W-1:0]      out_data_o,  // presented word
  input  wire logic         out_ready_i  // receiver takes word
);
  logic [W-1:0] spare;
  logic         spare_v;
  logic         push;
  logic         pop;

  assign push       = in_valid_i && !spare_v;
  assign pop        = out_valid_o && out_ready_i;
  assign in_ready_o = !spare_v;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      out_valid_o <= 1'b0;
      spare_v     <= 1'b0;
      out_data_o  <= '0;
      spare       <= '0;
    end else if (pop && !push) begin
      out_data_o  <= spare;
      out_valid_o <= spare_v;
      spare_v     <= 1'b0;
    end else if (push && !pop) begin
      if (!out_valid_o) begin
        out_data_o  <= in_data_i;
        out_valid_o <= 1'b1;
      end else begin
        spare   <= in_data_i;
        spare_v <= 1'b1;
      end
    end else if (push && pop) begin
      out_data_o <= in_data_i;
    end
  end
endmodule : irl_skid

// *** irl_link.sv ***
// Purpose: low-power control, host receive buffer with cts, ir packet framing
// Assumes: ir bytes are decoded by same-clock logic; photo-detect is async
// Notes:   the host buffer is forwarded as one packet with fixed overhead
//
// Overview of operation
// - photo-detect crossing its reference wakes the device from low power.
// - reset forces the device out of low power into initialization.
// - after init, ten seconds without ir activity while disconnected returns to low power.
// - handler-active is open collector: pulls low or releases to show running.
// - the ir bit rate is fixed at 9.6 kbaud, never selectable.
// - host receive buffer holds up to 29 bytes from the host.
// - cts goes high once 23 host bytes are buffered.
// - ir receive frames use a fixed 64-byte data block.
// - every packet sent adds 8 overhead bytes before its payload.
// - frames as short as 6 bytes are accepted.
// - the ir path is half duplex: no byte is pushed while receiving, but up to two buffered bytes can still go out.
// - at least one bit time passes between a received byte and the next push; up to two buffered bytes can go out sooner.
// - a fixed id string is reported, last two characters give revision.
// - the link moves disconnected, then discovery, then connected.
// - after cts rises, up to 6 more host bytes are still stored.
// - in low power the oscillator stops and handler-active is held low.
// - a dropped connection returns to disconnected ten seconds after last frame.
`timescale 1ns/10ps
module irl_link #(
  parameter int unsigned IDLE_CYCLES = irl_pkg::IDLE_CYC, // quiet time to sleep
  parameter logic [63:0] ID_NAME     = "IRLINK v",        // arbitrary id text
  parameter logic [15:0] ID_REV      = "01"               // arbitrary revision
) (
  input  wire logic              clk_i,                // system clock, 25 MHz
  input  wire logic              reset_n_i,            // synchronous reset, active low
  input  wire logic              photo_detect_above_i, // input above reference, async
  input  wire irl_pkg::irl_byte_t host_i,              // byte from host uart
  input  wire irl_pkg::irl_rx_t  ir_rx_i,              // decoded ir byte
  input  wire logic              ir_rx_busy_i,         // ir receiver mid byte
  input  wire logic              disc_start_i,         // discovery begun
  input  wire logic              disc_done_i,          // discovery completed
  input  wire logic              close_link_i,         // close link confirmed
  input  wire logic              ir_tx_ready_i,        // encoder takes byte
  input  wire logic [3:0]        id_index_i,           // id character index
  output irl_pkg::irl_byte_t     ir_tx_o,              // byte to ir encoder
  output logic                   cts_o,                // host flow stop, high stops
  output logic                   osc_en_o,             // oscillator run
  output logic                   handler_active_out_o, // open-collector level
  output logic                   handler_active_oe_o,  // high pulls pin low
  output irl_pkg::irl_link_t     link_state_o,         // connection stage
  output logic                   rx_frame_ok_o,        // frame length accepted
  output logic                   rx_frame_err_o,       // frame length refused
  output logic                   host_overrun_o,       // host byte dropped
  output logic [7:0]             id_char_o             // id character
);
  localparam logic [27:0] IDLE_LAST = 28'(IDLE_CYCLES - 1);
  localparam logic [4:0]  DEPTH     = 5'(irl_pkg::HOST_DEPTH);

  irl_pkg::irl_pwr_t next_pwr;
  irl_pkg::irl_pwr_t pwr;
  irl_pkg::irl_tx_t  tx_state;
  logic [1:0]        pd_sync;
  logic [27:0]       idle_cnt;
  logic [27:0]       link_cnt;
  logic [7:0]        hbuf [irl_pkg::HOST_DEPTH];
  logic [4:0]        wr_ptr;
  logic [4:0]        rd_ptr;
  logic [4:0]        host_cnt;
  logic [4:0]        next_cnt;
  logic [6:0]        rx_len;
  logic [11:0]       ta_cnt;
  logic [2:0]        hdr_cnt;
  logic              host_wr;
  logic              host_rd;
  logic              push_tx;
  logic              tx_room;
  logic              tx_gate;
  logic              activity;
  logic [7:0]        tx_byte;
  logic [79:0]       id_text;

  // the comparator output is asynchronous to the clock
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) pd_sync <= 2'b00;
    else            pd_sync <= {pd_sync[0], photo_detect_above_i};
  end

  assign activity = pd_sync[1] || ir_rx_i.valid;

  always_comb begin
    next_pwr = pwr;
    case (pwr)
      irl_pkg::PWR_LOW:  if (pd_sync[1]) next_pwr = irl_pkg::PWR_INIT;
      irl_pkg::PWR_INIT: next_pwr = irl_pkg::PWR_RUN;
      irl_pkg::PWR_RUN: begin
        if (link_state_o == irl_pkg::LINK_DISC && !activity && idle_cnt == IDLE_LAST)
          next_pwr = irl_pkg::PWR_LOW;
      end
      default: next_pwr = irl_pkg::PWR_INIT;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) pwr <= irl_pkg::PWR_INIT;
    else            pwr <= next_pwr;
  end

  // pin released while running, pulled low while asleep; the oscillator follows
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      handler_active_out_o <= 1'b0;
      handler_active_oe_o  <= 1'b0;
      osc_en_o             <= 1'b1;
    end else begin
      handler_active_out_o <= 1'b0;
      handler_active_oe_o  <= (next_pwr == irl_pkg::PWR_LOW);
      osc_en_o             <= (next_pwr != irl_pkg::PWR_LOW);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || activity || pwr != irl_pkg::PWR_RUN ||
        link_state_o != irl_pkg::LINK_DISC)
      idle_cnt <= '0;
    else if (idle_cnt != IDLE_LAST)
      idle_cnt <= idle_cnt + 28'h0000001;
  end

  // link stages; silence while not disconnected falls back after the timeout
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || next_pwr == irl_pkg::PWR_LOW) begin
      link_state_o <= irl_pkg::LINK_DISC;
      link_cnt     <= '0;
    end else begin
      if (ir_rx_i.valid && ir_rx_i.last) link_cnt <= '0;
      else if (link_state_o == irl_pkg::LINK_DISC) link_cnt <= '0;
      else link_cnt <= link_cnt + 28'h0000001;
      case (link_state_o)
        irl_pkg::LINK_DISC:
          if (disc_start_i) link_state_o <= irl_pkg::LINK_DISCOVERY;
        irl_pkg::LINK_DISCOVERY:
          if (link_cnt == IDLE_LAST) link_state_o <= irl_pkg::LINK_DISC;
          else if (disc_done_i) link_state_o <= irl_pkg::LINK_CONN;
        irl_pkg::LINK_CONN:
          if (close_link_i || link_cnt == IDLE_LAST)
            link_state_o <= irl_pkg::LINK_DISC;
        default: link_state_o <= irl_pkg::LINK_DISC;
      endcase
    end
  end

  // host buffer: bytes past the full 29 are dropped and flagged
  assign host_wr  = host_i.valid && host_cnt != DEPTH;
  assign next_cnt = host_cnt + 5'(host_wr) - 5'(host_rd);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_ptr         <= '0;
      rd_ptr         <= '0;
      host_cnt       <= '0;
      host_overrun_o <= 1'b0;
    end else begin
      host_cnt       <= next_cnt;
      host_overrun_o <= host_i.valid && !host_wr;
      if (host_wr) wr_ptr <= (wr_ptr == DEPTH - 5'h01) ? 5'h00 : wr_ptr + 5'h01;
      if (host_rd) rd_ptr <= (rd_ptr == DEPTH - 5'h01) ? 5'h00 : rd_ptr + 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (host_wr) hbuf[wr_ptr] <= host_i.data;
  end

  // cts also holds the host off until connected; it only drops when the
  // buffer has drained, which keeps a packet from closing on a short tail
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) cts_o <= 1'b1;
    else if (link_state_o != irl_pkg::LINK_CONN) cts_o <= 1'b1;
    else if (next_cnt >= 5'(irl_pkg::CTS_ON_LEVEL)) cts_o <= 1'b1;
    else if (next_cnt == 5'h00) cts_o <= 1'b0;
  end

  // turnaround guard: a full bit time at the fixed rate after each rx byte
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) ta_cnt <= '0;
    else if (ir_rx_i.valid || ir_rx_busy_i) ta_cnt <= 12'(irl_pkg::BIT_CYC);
    else if (ta_cnt != 12'h000) ta_cnt <= ta_cnt - 12'h001;
  end

  assign tx_gate = !ir_rx_busy_i && !ir_rx_i.valid && ta_cnt == 12'h000;
  assign push_tx = tx_gate && tx_room &&
                   (tx_state == irl_pkg::TX_HDR || tx_state == irl_pkg::TX_DATA);
  assign host_rd = push_tx && tx_state == irl_pkg::TX_DATA;
  assign tx_byte = (tx_state == irl_pkg::TX_HDR) ? irl_pkg::OVH_FILL : hbuf[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_state <= irl_pkg::TX_IDLE;
      hdr_cnt  <= '0;
    end else begin
      case (tx_state)
        irl_pkg::TX_IDLE: begin
          hdr_cnt <= '0;
          if (link_state_o == irl_pkg::LINK_CONN && host_cnt != 5'h00 && cts_o)
            tx_state <= irl_pkg::TX_HDR;
        end
        irl_pkg::TX_HDR:
          if (push_tx) begin
            hdr_cnt <= hdr_cnt + 3'h1;
            if (hdr_cnt == 3'(irl_pkg::OVH_BYTES - 1)) tx_state <= irl_pkg::TX_DATA;
          end
        irl_pkg::TX_DATA:
          if (push_tx && host_cnt == 5'h01) tx_state <= irl_pkg::TX_IDLE;
        default: tx_state <= irl_pkg::TX_IDLE;
      endcase
    end
  end

  irl_skid #(
    .W(8)
  ) u_tx_buf (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .in_valid_i (push_tx),
    .in_data_i  (tx_byte),
    .in_ready_o (tx_room),
    .out_valid_o(ir_tx_o.valid),
    .out_data_o (ir_tx_o.data),
    .out_ready_i(ir_tx_ready_i)
  );

  // frame length check against the fixed block
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rx_len         <= '0;
      rx_frame_ok_o  <= 1'b0;
      rx_frame_err_o <= 1'b0;
    end else begin
      rx_frame_ok_o  <= 1'b0;
      rx_frame_err_o <= 1'b0;
      if (ir_rx_i.valid) begin
        if (ir_rx_i.last) begin
          rx_len         <= '0;
          rx_frame_ok_o  <= rx_len >= 7'(irl_pkg::MIN_FRAME - 1) &&
                            rx_len <  7'(irl_pkg::IR_BLOCK);
          rx_frame_err_o <= rx_len <  7'(irl_pkg::MIN_FRAME - 1) ||
                            rx_len >= 7'(irl_pkg::IR_BLOCK);
        end else if (rx_len != 7'h7F) begin
          rx_len <= rx_len + 7'h01;
        end
      end
    end
  end

  // id string; text and revision values are arbitrary
  assign id_text = {ID_NAME, ID_REV};

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) id_char_o <= irl_pkg::ID_NONE;
    else if (id_index_i < 4'(irl_pkg::ID_LEN))
      id_char_o <= 8'(id_text >> (7'h48 - {id_index_i, 3'b000}));
    else id_char_o <= irl_pkg::ID_NONE;
  end

  sequence s_rx_byte;
    ir_rx_i.valid;
  endsequence

  sequence s_quiet_tx;
    !push_tx [*8];
  endsequence

  a_wake_on_detect: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    pwr == irl_pkg::PWR_LOW && pd_sync[1] |=> pwr == irl_pkg::PWR_INIT)
    else $error("no wake on photo detect");

  a_reset_to_init: assert property (@(posedge clk_i)
    $rose(reset_n_i) |-> pwr == irl_pkg::PWR_INIT && osc_en_o)
    else $error("reset did not leave low power");

  a_sleep_after_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    pwr == irl_pkg::PWR_RUN && idle_cnt == IDLE_LAST && !activity &&
    link_state_o == irl_pkg::LINK_DISC |=> pwr == irl_pkg::PWR_LOW)
    else $error("idle timeout missed");

  a_low_power_pins: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    pwr == irl_pkg::PWR_LOW |-> handler_active_oe_o && !osc_en_o &&
    !handler_active_out_o)
    else $error("low power pins wrong");

  a_cts_at_fill: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    host_cnt >= 5'h17 |-> cts_o)
    else $error("cts low at fill level");

  a_buffer_bound: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    host_cnt == 5'h1D && host_i.valid |=> host_overrun_o && host_cnt <= 5'h1D)
    else $error("host buffer bound broken");

  a_turnaround_gap: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_rx_byte |-> ##1 s_quiet_tx)
    else $error("sent inside turnaround");

  a_no_full_duplex: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ir_rx_busy_i |-> !push_tx)
    else $error("sent while receiving");

  a_header_length: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tx_state == irl_pkg::TX_DATA && $past(tx_state) == irl_pkg::TX_HDR
    |-> $past(hdr_cnt) == 3'h7 && hdr_cnt == 3'h0)
    else $error("overhead length wrong");

  a_conn_timeout: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    link_state_o == irl_pkg::LINK_CONN && link_cnt == IDLE_LAST &&
    pwr == irl_pkg::PWR_RUN |=> link_state_o == irl_pkg::LINK_DISC)
    else $error("connection timeout missed");

  a_short_frame_ok: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ir_rx_i.valid && ir_rx_i.last && rx_len == 7'h05 |=> rx_frame_ok_o)
    else $error("six byte frame refused");
endmodule : irl_link

// *** irl_primary_model.sv ***
// Purpose: behavioural primary infrared device seen through the byte decoder and encoder
// Assumes: same clock as the link block, bytes already decoded into the rx struct
// Notes:   idle data lines show the inverse of the last byte, never a stale copy
`timescale 1ns/10ps
module irl_primary_model (
  input  wire logic               clk_i,        // system clock
  input  wire irl_pkg::irl_byte_t ir_tx_i,      // byte offered by the device
  output irl_pkg::irl_rx_t        ir_rx_o,      // decoded byte to the device
  output logic                    ir_rx_busy_o, // receiver inside a byte
  output logic                    disc_start_o, // discovery begun
  output logic                    disc_done_o,  // discovery completed
  output logic                    close_link_o, // close link confirmed
  output logic                    tx_ready_o    // encoder takes byte
);
  logic       stall;
  logic [7:0] got_q[$];

  initial begin
    ir_rx_o = '0;
    ir_rx_busy_o = 1'b0;
    {disc_start_o, disc_done_o, close_link_o} = 3'h0;
    tx_ready_o = 1'b0;
    stall = 1'b0;
  end

  // a stalled encoder holds ready low, so the device has to keep its words
  always @(posedge clk_i) begin
    tx_ready_o <= !stall;
    if (ir_tx_i.valid && tx_ready_o) got_q.push_back(ir_tx_i.data);
  end

  // frames of any length go out back to back; busy is raised by the bench only
  task automatic send_frame(input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge clk_i);
      ir_rx_busy_o <= 1'b0;
      ir_rx_o <= '{valid: 1'b1, last: (i == len - 1), data: 8'(8'hA0 + i)};
    end
    @(posedge clk_i);
    ir_rx_o <= '{valid: 1'b0, last: 1'b0, data: ~ir_rx_o.data};
  endtask : send_frame

  // 0 starts discovery, 1 completes it, 2 confirms close
  task automatic link_pulse(input int which);
    @(posedge clk_i);
    disc_start_o <= (which == 0);
    disc_done_o  <= (which == 1);
    close_link_o <= (which == 2);
    @(posedge clk_i);
    {disc_start_o, disc_done_o, close_link_o} <= 3'h0;
  endtask : link_pulse
endmodule : irl_primary_model

// *** testbench.sv ***
// Purpose: self-checking bench for the ir link power and buffering block
// Assumes: quiet time shortened to IDLE cycles; the bench plays the host uart
// Notes:   IDLE must exceed one bit time plus a packet, or the link drops mid test
`timescale 1ns/10ps
module testbench;
  localparam int unsigned IDLE = 4000;
  logic clk_i, reset_n_i, photo_detect_above_i, ir_rx_busy_i, ir_tx_ready_i;
  logic disc_start_i, disc_done_i, close_link_i, cts_o, osc_en_o, ha_pin;
  logic handler_active_out_o, handler_active_oe_o, rx_frame_ok_o, rx_frame_err_o;
  logic host_overrun_o;
  logic [3:0] id_index_i;
  logic [7:0] id_char_o;
  irl_pkg::irl_byte_t host_i, ir_tx_o;
  irl_pkg::irl_rx_t ir_rx_i;
  irl_pkg::irl_link_t link_state_o;
  int errors, tests_run, cyc, overruns;

  irl_link #(.IDLE_CYCLES(IDLE)) irl_link_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .photo_detect_above_i(photo_detect_above_i),
    .host_i(host_i), .ir_rx_i(ir_rx_i), .ir_rx_busy_i(ir_rx_busy_i),
    .disc_start_i(disc_start_i), .disc_done_i(disc_done_i), .close_link_i(close_link_i),
    .ir_tx_ready_i(ir_tx_ready_i), .id_index_i(id_index_i), .ir_tx_o(ir_tx_o),
    .cts_o(cts_o), .osc_en_o(osc_en_o), .handler_active_out_o(handler_active_out_o),
    .handler_active_oe_o(handler_active_oe_o), .link_state_o(link_state_o),
    .rx_frame_ok_o(rx_frame_ok_o), .rx_frame_err_o(rx_frame_err_o),
    .host_overrun_o(host_overrun_o), .id_char_o(id_char_o));

  irl_primary_model irl_primary_model_inst (
    .clk_i(clk_i), .ir_tx_i(ir_tx_o), .ir_rx_o(ir_rx_i), .ir_rx_busy_o(ir_rx_busy_i),
    .disc_start_o(disc_start_i), .disc_done_o(disc_done_i), .close_link_o(close_link_i),
    .tx_ready_o(ir_tx_ready_i));

  // pull-up on the open-collector pin
  assign ha_pin = handler_active_oe_o ? handler_active_out_o : 1'b1;

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (host_overrun_o === 1'b1) overruns <= overruns + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic bound(input string what, input int n, input int lim);
    if (n >= lim) begin
      errors++;
      $display("ERROR %s expected done seen timeout", what);
      results();
    end
  endtask : bound

  task automatic host_send(input logic [7:0] b);
    @(posedge clk_i) host_i <= '{valid: 1'b1, data: b};
    @(posedge clk_i) host_i <= '{valid: 1'b0, data: ~b};
    #1;
  endtask : host_send

  task automatic t_reset();
    check("cts", cts_o, 1);
    check("osc", osc_en_o, 1);
    check("pin", ha_pin, 1);
    check("link", link_state_o, irl_pkg::LINK_DISC);
    check("tx valid", ir_tx_o.valid, 0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_id();
    int idx[4] = '{0, 8, 9, 10};
    logic [7:0] exp[4] = '{8'h49, 8'h30, 8'h31, 8'h00};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i) id_index_i <= 4'(idx[i]);
      @(posedge clk_i) #1 check("id char", id_char_o, exp[i]);
    end
    $display("test id done");
  endtask : t_id

  task automatic t_frames();
    int len[4] = '{5, 6, 64, 65};
    logic ok[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      irl_primary_model_inst.send_frame(len[i]);
      #1 check("frame ok", rx_frame_ok_o, ok[i]);
      check("frame err", rx_frame_err_o, !ok[i]);
    end
    $display("test frames done");
  endtask : t_frames

  task automatic t_link();
    irl_pkg::irl_link_t exp[3] = '{irl_pkg::LINK_DISCOVERY, irl_pkg::LINK_CONN,
                                   irl_pkg::LINK_DISC};
    for (int w = 0; w < 3; w++) begin
      irl_primary_model_inst.link_pulse(w);
      #1 check("link", link_state_o, exp[w]);
    end
    $display("test link done");
  endtask : t_link

  task automatic t_flow();
    int n;
    irl_primary_model_inst.link_pulse(0);
    irl_primary_model_inst.link_pulse(1);
    for (n = 0; n < 8 && cts_o !== 1'b0; n++) @(posedge clk_i);
    bound("cts open", n, 8);
    @(posedge clk_i) irl_primary_model_inst.stall <= 1'b1;
    // the host ignores cts on purpose to reach the spare bytes and one more
    for (int i = 0; i < 30; i++) begin
      host_send(8'(8'h10 + i));
      if (i == 21) check("cts at 22", cts_o, 0);
      if (i == 22) check("cts at 23", cts_o, 1);
      if (i == 28) check("spare kept", overruns, 0);
    end
    repeat (2) @(posedge clk_i);
    #1 check("overrun", overruns, 1);
    @(posedge clk_i) irl_primary_model_inst.stall <= 1'b0;
    // the turnaround guard from the last frame still runs, about one bit time
    for (n = 0; n < 3200 && irl_primary_model_inst.got_q.size() < 37; n++) @(posedge clk_i);
    bound("drain", n, 3200);
    for (int i = 0; i < 37; i++)
      check("tx byte", irl_primary_model_inst.got_q[i], i < 8 ? 8'hFF : 8'(8'h08 + i));
    for (n = 0; n < 20 && cts_o !== 1'b0; n++) @(posedge clk_i);
    bound("cts release", n, 20);
    $display("test flow done");
  endtask : t_flow

  task automatic t_turn();
    int n;
    int t0;
    irl_primary_model_inst.got_q.delete();
    irl_primary_model_inst.send_frame(6);
    for (int i = 0; i < 23; i++) host_send(8'h55);
    @(posedge clk_i) irl_primary_model_inst.ir_rx_busy_o <= 1'b1;
    repeat (300) @(posedge clk_i);
    check("tx while rx", irl_primary_model_inst.got_q.size(), 0);
    irl_primary_model_inst.ir_rx_busy_o <= 1'b0;
    t0 = cyc;
    for (n = 0; n < 3000 && ir_tx_o.valid !== 1'b1; n++) @(posedge clk_i);
    bound("turnaround", n, 3000);
    check("gap kept", (cyc - t0) >= irl_pkg::BIT_CYC, 1);
    check("gap short", (cyc - t0) <= irl_pkg::BIT_CYC + 20, 1);
    for (n = 0; n < 200 && cts_o !== 1'b0; n++) @(posedge clk_i);
    bound("cts release", n, 200);
    $display("test turnaround done");
  endtask : t_turn

  task automatic t_drop();
    int n;
    irl_primary_model_inst.send_frame(6);
    for (n = 0; n < IDLE + 50 && link_state_o !== irl_pkg::LINK_DISC; n++) @(posedge clk_i);
    bound("link drop", n, IDLE + 50);
    check("drop late", n > IDLE - 10, 1);
    #1 check("cts shut", cts_o, 1);
    $display("test drop done");
  endtask : t_drop

  task automatic t_sleep();
    int n;
    irl_primary_model_inst.send_frame(6);
    for (n = 0; n < IDLE + 100 && osc_en_o !== 1'b0; n++) @(posedge clk_i);
    bound("sleep", n, IDLE + 100);
    check("sleep late", n > IDLE - 10, 1);
    #1 check("pin low", ha_pin, 0);
    @(posedge clk_i) photo_detect_above_i <= 1'b1;
    for (n = 0; n < 8 && osc_en_o !== 1'b1; n++) @(posedge clk_i);
    bound("wake", n, 8);
    @(posedge clk_i) photo_detect_above_i <= 1'b0;
    #1 check("pin high", ha_pin, 1);
    for (n = 0; n < IDLE + 100 && osc_en_o !== 1'b0; n++) @(posedge clk_i);
    bound("sleep again", n, IDLE + 100);
    @(posedge clk_i) reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i) #1 check("reset wake", osc_en_o, 1);
    $display("test sleep done");
  endtask : t_sleep

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  initial begin
    {reset_n_i, photo_detect_above_i, id_index_i} = 6'h00;
    host_i = '0;
    {errors, tests_run, cyc, overruns} = '0;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 t_reset();
    t_id();
    t_frames();
    t_link();
    t_flow();
    t_turn();
    t_drop();
    t_sleep();
    results();
  end
endmodule : testbench
